// >>> rtl/pbi_defines.svh
`ifndef PBI_DEFINES_SVH
`define PBI_DEFINES_SVH

// bus command codes as seen on the command/byte-enable pins
`define PBI_CMD_MEM_RD 4'h6
`define PBI_CMD_MEM_WR 4'h7
// burst-order field in the low address bits
`define PBI_BURST_LINEAR 2'h0
// window of the memory decode
`define PBI_BAR_BASE 32'h8000_0000
`define PBI_BAR_MASK 32'hfff0_0000
// write buffer geometry: byte enables above the data word
`define PBI_FIFO_DEPTH 32
`define PBI_WORD_W 36
// bus clocks without a device select before the master gives up
`define PBI_DEVSEL_LIMIT 3'h4

`endif

// >>> rtl/pbi_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module pbi_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // streams
  pbi_stream_if.snk inS,
  pbi_stream_if.src outS
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire push;
  wire pop;

  // honest flags; depth is assumed a power of two so pointers wrap
  assign push = inS.valid & inS.ready;
  assign pop = outS.valid & outS.ready;
  assign inS.ready = count_q != (AW+1)'(DEPTH);
  assign inS.spare = count_q < (AW+1)'(DEPTH - 1);
  assign outS.valid = count_q != '0;
  assign outS.data = mem[rdPtr_q];

  // storage has no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inS.data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pbi_par_gen.sv
`timescale 1ns/1ns
`default_nettype none
module pbi_par_gen (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // value driven on the bus this cycle
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic drive,
  // parity pin, one clock behind
  output logic par,
  output logic parOe_n
);
  logic par_q;
  logic parOe_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      par_q <= 1'b0;
      parOe_q <= 1'b0;
    end else begin
      par_q <= ^{ad, cbe};
      parOe_q <= drive;
    end
  end

  assign par = par_q;
  assign parOe_n = !parOe_q;

  chk_par_even: assert property (@(posedge clk) disable iff (!reset_n)
    !parOe_n |-> (^{$past(ad), $past(cbe), par}) == 1'b0)
    else $error("parity is not even");
  chk_par_delay: assert property (@(posedge clk) disable iff (!reset_n)
    drive |=> !parOe_n)
    else $error("parity not driven after a driven cycle");
endmodule
`default_nettype wire

// >>> rtl/pbi_pci_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "pbi_defines.svh"
module pbi_pci_core #(
  parameter logic [31:0] BAR_BASE = `PBI_BAR_BASE,
  parameter logic [31:0] BAR_MASK = `PBI_BAR_MASK,
  parameter int FIFO_DEPTH = `PBI_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // address/data and command/byte-enable pins
  input wire logic [31:0] adIn,
  output logic [31:0] adOut,
  output logic adOe_n,
  input wire logic [3:0] cbenIn,
  output logic [3:0] cbenOut,
  output logic cbenOe_n,
  input wire logic parIn,
  output logic parOut,
  output logic parOe_n,
  // control pins
  input wire logic frameIn_n,
  output logic frameOut_n,
  output logic frameOe_n,
  input wire logic irdyIn_n,
  output logic irdyOut_n,
  output logic irdyOe_n,
  input wire logic trdyIn_n,
  output logic trdyOut_n,
  output logic trdyOe_n,
  input wire logic devselIn_n,
  output logic devselOut_n,
  output logic devselOe_n,
  input wire logic stopIn_n,
  output logic stopOut_n,
  output logic stopOe_n,
  // arbitration
  output logic reqOut_n,
  output logic reqOe_n,
  input wire logic gntIn_n,
  // target write stream to user logic
  output logic twValid,
  input wire logic twReady,
  output logic [31:0] twData,
  output logic [3:0] twBe,
  output logic parErr,
  // target read port, data returned in the same cycle
  output logic [31:0] trAddr,
  input wire logic [31:0] trData,
  // master single-word write request
  input wire logic mValid,
  input wire logic [31:0] mAddr,
  input wire logic [31:0] mData,
  input wire logic [3:0] mBe,
  output logic mDone,
  output logic mAbort
);
  pbi_pkg::tstate_e tState_q;
  pbi_pkg::tstate_e tState_d;
  pbi_pkg::mstate_e mState_q;
  pbi_pkg::mstate_e mState_d;
  logic frameSeen_q;
  logic tWrite_q;
  logic tLinear_q;
  logic [29:0] tAddr_q;
  logic tDevsel_q;
  logic tTrdy_q;
  logic tStop_q;
  logic [31:0] tAd_q;
  logic mReq_q;
  logic mFrame_q;
  logic mIrdy_q;
  logic [31:0] mAd_q;
  logic [3:0] mCbe_q;
  logic [2:0] mWait_q;
  logic mDone_q;
  logic mAbort_q;
  logic wrChk_q;
  logic [35:0] chkWord_q;
  logic parErr_q;
  logic parOeRaw_n;

  pbi_stream_if #(.W(`PBI_WORD_W)) wrIn ();
  pbi_stream_if #(.W(`PBI_WORD_W)) wrOut ();

  // bus decode; every pin is used only as sampled at the rising edge
  // edge sampling
  wire busIdle = frameIn_n & irdyIn_n;
  wire addrPhase = !frameIn_n & frameSeen_q;
  wire cmdWr = cbenIn == `PBI_CMD_MEM_WR;
  wire cmdRd = cbenIn == `PBI_CMD_MEM_RD;
  wire inWindow = (adIn & BAR_MASK) == BAR_BASE;
  wire hit = addrPhase & inWindow & (cmdWr | cmdRd) & (mState_q != pbi_pkg::M_ADDR);
  wire tInData = tState_q == pbi_pkg::T_DATA;
  wire tXfer = tInData & tTrdy_q & !irdyIn_n;
  // last phase ends when frame is gone, the initiator is ready and trdy or stop is asserted
  wire tLast = tInData & frameIn_n & !irdyIn_n & (tTrdy_q | tStop_q);
  wire tNextTrdy = tWrite_q ? wrIn.spare : 1'b1;
  wire tRdDrive = tInData & !tWrite_q;
  wire tCtrlDrive = tInData | (tState_q == pbi_pkg::T_TURN);
  wire [29:0] tAddrNext = tXfer ? tAddr_q + 30'h1 : tAddr_q;
  wire mAdDrive = (mState_q == pbi_pkg::M_ADDR) | (mState_q == pbi_pkg::M_DATA);
  wire mCtrlDrive = mAdDrive | (mState_q == pbi_pkg::M_TURN);
  wire mGo = !gntIn_n & busIdle & (tState_q == pbi_pkg::T_IDLE);
  wire mTimeout = devselIn_n & (mWait_q == `PBI_DEVSEL_LIMIT);

  // frame history for spotting the address phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frameSeen_q <= 1'b1;
    end else begin
      frameSeen_q <= frameIn_n;
    end
  end

  // target sequence
  // address then data
  always_comb begin
    tState_d = tState_q;
    case (tState_q)
      pbi_pkg::T_IDLE: begin
        if (hit) begin
          tState_d = pbi_pkg::T_DECODE;
        end
      end
      pbi_pkg::T_DECODE: tState_d = pbi_pkg::T_DATA;
      pbi_pkg::T_DATA: begin
        if (tLast) begin
          tState_d = pbi_pkg::T_TURN;
        end
      end
      pbi_pkg::T_TURN: tState_d = pbi_pkg::T_IDLE;
      default: tState_d = pbi_pkg::T_IDLE;
    endcase
  end

  // target strobes; decode takes a full cycle so select comes late
  // medium decode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tState_q <= pbi_pkg::T_IDLE;
      tDevsel_q <= 1'b0;
      tTrdy_q <= 1'b0;
      tStop_q <= 1'b0;
    end else begin
      tState_q <= tState_d;
      tDevsel_q <= tState_d == pbi_pkg::T_DATA;
      if (tState_d != pbi_pkg::T_DATA) begin
        tTrdy_q <= 1'b0;
        tStop_q <= 1'b0;
      end else if (tState_q == pbi_pkg::T_DECODE) begin
        tTrdy_q <= tNextTrdy;
        tStop_q <= !tLinear_q;
      end else begin
        tTrdy_q <= (tLinear_q | !(tXfer | tStop_q)) & tNextTrdy;
      end
    end
  end

  // captured request; burst field compared, read enables unused
  // word address split
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tWrite_q <= 1'b0;
      tLinear_q <= 1'b0;
      tAddr_q <= '0;
      tAd_q <= '0;
    end else begin
      if (tState_q == pbi_pkg::T_IDLE && hit) begin
        tWrite_q <= cmdWr;
        tLinear_q <= adIn[1:0] == `PBI_BURST_LINEAR;
        tAddr_q <= adIn[31:2];
      end else begin
        tAddr_q <= tAddrNext;
      end
      tAd_q <= trData;
    end
  end

  // read fetch looks one word ahead so the bus never stalls a burst
  assign trAddr = {tAddrNext, 2'b00};

  // write words enter the buffer; trdy only rises with two free slots
  // byte order kept
  assign wrIn.valid = tXfer & tWrite_q;
  assign wrIn.data = {~cbenIn, adIn};
  assign wrOut.ready = twReady;
  assign twValid = wrOut.valid;
  assign twData = wrOut.data[31:0];
  assign twBe = wrOut.data[35:32];

  pbi_fifo #(.W(`PBI_WORD_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk(clk),
    .reset_n(reset_n),
    .inS(wrIn),
    .outS(wrOut)
  );

  // write parity check one clock after each accepted word
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrChk_q <= 1'b0;
      chkWord_q <= '0;
      parErr_q <= 1'b0;
    end else begin
      wrChk_q <= wrIn.valid;
      chkWord_q <= {cbenIn, adIn};
      parErr_q <= wrChk_q & (^{chkWord_q, parIn});
    end
  end
  assign parErr = parErr_q;

  // master sequence: single-phase memory write, retried on stop
  // idle until granted
  always_comb begin
    mState_d = mState_q;
    case (mState_q)
      pbi_pkg::M_IDLE: begin
        if (mValid) begin
          mState_d = pbi_pkg::M_REQ;
        end
      end
      pbi_pkg::M_REQ: begin
        if (mGo) begin
          mState_d = pbi_pkg::M_ADDR;
        end
      end
      pbi_pkg::M_ADDR: mState_d = pbi_pkg::M_DATA;
      pbi_pkg::M_DATA: begin
        if (!trdyIn_n || !stopIn_n || mTimeout) begin
          mState_d = pbi_pkg::M_TURN;
        end
      end
      pbi_pkg::M_TURN: mState_d = pbi_pkg::M_IDLE;
      default: mState_d = pbi_pkg::M_IDLE;
    endcase
  end

  // master strobes; frame lasts one clock since there is one data phase
  // frame starts access
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mState_q <= pbi_pkg::M_IDLE;
      mReq_q <= 1'b0;
      mFrame_q <= 1'b0;
      mIrdy_q <= 1'b0;
      mAd_q <= '0;
      mCbe_q <= '0;
      mWait_q <= '0;
      mDone_q <= 1'b0;
      mAbort_q <= 1'b0;
    end else begin
      mState_q <= mState_d;
      mReq_q <= mState_d == pbi_pkg::M_REQ;
      mFrame_q <= mState_d == pbi_pkg::M_ADDR;
      mIrdy_q <= mState_d == pbi_pkg::M_DATA;
      mDone_q <= (mState_q == pbi_pkg::M_DATA) & !trdyIn_n;
      mAbort_q <= (mState_q == pbi_pkg::M_DATA) & trdyIn_n & stopIn_n & mTimeout;
      if (mState_d == pbi_pkg::M_ADDR) begin
        mAd_q <= {mAddr[31:2], `PBI_BURST_LINEAR};
        mCbe_q <= `PBI_CMD_MEM_WR;
      end else if (mState_d == pbi_pkg::M_DATA) begin
        mAd_q <= mData;
        mCbe_q <= ~mBe;
      end
      mWait_q <= (mState_q == pbi_pkg::M_DATA) ? mWait_q + 3'h1 : 3'h0;
    end
  end

  // parity ownership: initiator for address and write, target for read
  // parity owner
  pbi_par_gen uPar (
    .clk(clk),
    .reset_n(reset_n),
    .ad(mAdDrive ? mAd_q : tAd_q),
    .cbe(mAdDrive ? mCbe_q : cbenIn),
    .drive(mAdDrive | tRdDrive),
    .par(parOut),
    .parOe_n(parOeRaw_n)
  );

  // pin drive; reset gates enables directly so floating needs no clock
  // float in reset
  assign adOut = mAdDrive ? mAd_q : tAd_q;
  assign adOe_n = !(reset_n & (mAdDrive | tRdDrive));
  assign cbenOut = mCbe_q;
  assign cbenOe_n = !(reset_n & mAdDrive);
  assign parOe_n = !reset_n | parOeRaw_n;
  assign frameOut_n = !mFrame_q;
  assign irdyOut_n = !mIrdy_q;
  assign frameOe_n = !(reset_n & mCtrlDrive);
  assign irdyOe_n = !(reset_n & mCtrlDrive);
  assign trdyOut_n = !tTrdy_q;
  assign devselOut_n = !tDevsel_q;
  assign stopOut_n = !tStop_q;
  assign trdyOe_n = !(reset_n & tCtrlDrive);
  assign devselOe_n = !(reset_n & tCtrlDrive);
  assign stopOe_n = !(reset_n & tCtrlDrive);
  assign reqOut_n = !mReq_q;
  assign reqOe_n = !reset_n;
  assign mDone = mDone_q;
  assign mAbort = mAbort_q;

  chk_devsel_medium: assert property (@(posedge clk) disable iff (!reset_n)
    (tState_q == pbi_pkg::T_IDLE && hit) |=> devselOut_n ##1 !devselOut_n)
    else $error("device select not two clocks after address");
  chk_burst_disc: assert property (@(posedge clk) disable iff (!reset_n)
    (tXfer && !tLinear_q) |=> trdyOut_n)
    else $error("non-linear burst moved a second word");
  chk_linear_nostop: assert property (@(posedge clk) disable iff (!reset_n)
    (tInData && tLinear_q) |-> stopOut_n)
    else $error("linear burst was stopped");
  chk_push_room: assert property (@(posedge clk) disable iff (!reset_n)
    wrIn.valid |-> wrIn.ready)
    else $error("write word lost to a full buffer");
  chk_frame_shape: assert property (@(posedge clk) disable iff (!reset_n)
    (mState_q == pbi_pkg::M_ADDR) |-> (!frameOut_n && !frameOe_n) ##1
    (frameOut_n && !irdyOut_n))
    else $error("frame not framing a single phase");
  chk_burst_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (mState_q == pbi_pkg::M_ADDR) |-> adOut[1:0] == `PBI_BURST_LINEAR)
    else $error("master address not linear order");
  chk_reset_float: assert property (@(posedge clk)
    !reset_n |-> (adOe_n && cbenOe_n && parOe_n && frameOe_n && trdyOe_n && devselOe_n))
    else $error("bus driven during reset");
  chk_par_hold: assert property (@(posedge clk) disable iff (!reset_n)
    ((mState_q == pbi_pkg::M_DATA && !trdyIn_n) || (tXfer && !tWrite_q)) |=> !parOe_n)
    else $error("parity released before the phase after completion");
  chk_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (tState_q == pbi_pkg::T_IDLE && mState_q == pbi_pkg::M_IDLE) |-> (adOe_n && devselOe_n))
    else $error("bus driven while idle");
endmodule
`default_nettype wire

// >>> rtl/pbi_pkg.sv
package pbi_pkg;
  typedef enum {T_IDLE, T_DECODE, T_DATA, T_TURN} tstate_e;
  typedef enum {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} mstate_e;
endpackage

// >>> rtl/pbi_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
// one valid/ready word stream; spare says two more words still fit
interface pbi_stream_if #(parameter int W = 36) ();
  logic valid;
  logic ready;
  logic spare;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready, input spare);
  modport snk(input valid, input data, output ready, output spare);
endinterface
`default_nettype wire

// >>> verif/pbi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side agent: initiator towards the core's target, plain target for its master
module pbi_host_model (
  // clock
  input wire logic clk,
  // resolved bus lines
  input wire logic [31:0] adW,
  input wire logic [3:0] cbenW,
  input wire logic frameW_n,
  input wire logic irdyW_n,
  input wire logic trdyW_n,
  input wire logic devselW_n,
  input wire logic stopW_n,
  // own drive values, enables active high
  output logic [31:0] hAd,
  output logic hAdEn,
  output logic [3:0] hCben,
  output logic hCbenEn,
  output logic hPar,
  output logic hParEn,
  output logic hFrame_n,
  output logic hIrdy_n,
  output logic hMstEn,
  output logic hTrdy_n,
  output logic hDevsel_n,
  output logic hTgtEn
);
  int wordsDone = 0;
  int dselLat = 0;
  logic tgtOn = 1'b0;
  logic framePrev = 1'b1;
  logic [1:0] tPh = 2'h0;
  logic [31:0] capAddr, capData, rdData;
  logic [3:0] capCben;
  initial begin
    {hAdEn, hCbenEn, hParEn, hMstEn, hTgtEn, hPar} = 6'h00;
    {hFrame_n, hIrdy_n, hTrdy_n, hDevsel_n} = 4'hf;
    hAd = 32'h0;
    hCben = 4'h0;
  end
  // parity of last clock's own drive
  always @(posedge clk) begin
    hPar <= ^{hAd, hCben};
    hParEn <= hAdEn;
  end
  // target side: decode, one data phase, turn-around
  always @(posedge clk) begin
    framePrev <= frameW_n;
    if (tPh == 2'h0 && tgtOn && !frameW_n && framePrev && cbenW == 4'h7) begin
      capAddr <= adW;
      tPh <= 2'h1;
    end else if (tPh == 2'h1) begin
      {hTgtEn, hDevsel_n, hTrdy_n} <= 3'b100;
      tPh <= 2'h2;
    end else if (tPh == 2'h2 && !irdyW_n && !trdyW_n) begin
      capData <= adW;
      capCben <= cbenW;
      {hDevsel_n, hTrdy_n} <= 2'b11;
      tPh <= 2'h3;
    end else if (tPh == 2'h3) begin
      hTgtEn <= 1'b0;
      tPh <= 2'h0;
    end
  end
  // one address phase, then n data phases
  task automatic xfer(input logic [31:0] addr, input logic [3:0] cmd,
      input logic [31:0] d0, input logic [3:0] be, input int n);
    int w;
    w = 0;
    wordsDone = 0;
    dselLat = 0;
    {hMstEn, hFrame_n, hAdEn, hCbenEn} <= 4'b1011;
    hAd <= addr;
    hCben <= cmd;
    @(posedge clk);
    hFrame_n <= (n == 1);
    hIrdy_n <= 1'b0;
    hCben <= be;
    hAd <= d0;
    hAdEn <= (cmd == 4'h7);
    while (w < 1000) begin
      @(posedge clk);
      w++;
      if (!devselW_n && dselLat == 0) dselLat = w;
      if (!trdyW_n) begin
        wordsDone++;
        rdData = adW;
        hAd <= d0 + wordsDone;
        if (wordsDone == n - 1) hFrame_n <= 1'b1;
      end
      if (hFrame_n && (!trdyW_n || !stopW_n)) break;
      if (!stopW_n) hFrame_n <= 1'b1;
      // nobody claimed the cycle: give up as master abort
      if (dselLat == 0 && w == 5) break;
    end
    {hIrdy_n, hFrame_n, hAdEn, hCbenEn} <= 4'b1100;
    @(posedge clk);
    hMstEn <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] be;
    logic [7:0] n;
    logic [7:0] expN;
    logic [7:0] expLat;
  } pbi_row_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic gntIn_n = 1'b1;
  logic twReady = 1'b1;
  logic mValid = 1'b0;
  logic [31:0] rdPat = 32'h0;
  logic [31:0] mAddr = 32'h0;
  logic [31:0] mData = 32'h0;
  logic [3:0] mBe = 4'h0;
  logic [31:0] adW, adOut, hAd, twData, trAddr, d0;
  logic [31:0] adPrev = 32'h0;
  logic [3:0] cbenW, cbenOut, hCben, twBe;
  logic [3:0] cbPrev = 4'h0;
  logic parPrev = 1'b0;
  logic pChk = 1'b0;
  logic pExp = 1'b0;
  logic adOe_n, cbenOe_n, parOut, parOe_n, parW, hPar, hAdEn, hCbenEn, hParEn;
  logic frameOut_n, frameOe_n, irdyOut_n, irdyOe_n, trdyOut_n, trdyOe_n;
  logic devselOut_n, devselOe_n, stopOut_n, stopOe_n, reqOut_n, reqOe_n;
  logic frameW_n, irdyW_n, trdyW_n, devselW_n, stopW_n, hFrame_n, hIrdy_n;
  logic hMstEn, hTrdy_n, hDevsel_n, hTgtEn, twValid, parErr, mDone, mAbort;
  int errCount = 0;
  int testsRun = 0;
  int cyc = 0;
  pbi_row_s r;
  pbi_row_s rows [7] = '{
    '{32'h8000_0010, 4'h0, 8'd3, 8'd3, 8'd2},
    '{32'h800f_fffc, 4'ha, 8'd1, 8'd1, 8'd2},
    '{32'h8000_0021, 4'h0, 8'd2, 8'd1, 8'd2},
    '{32'h8000_0022, 4'h3, 8'd2, 8'd1, 8'd2},
    '{32'h8000_0023, 4'h5, 8'd2, 8'd1, 8'd2},
    '{32'h8010_0000, 4'h0, 8'd1, 8'd0, 8'd0},
    '{32'h7fff_fffc, 4'h0, 8'd1, 8'd0, 8'd0}};
  logic [35:0] expQ [$];
  // released lines without a pull-up show the inverse of their last level
  assign adW = !adOe_n ? adOut : hAdEn ? hAd : ~adPrev;
  assign cbenW = !cbenOe_n ? cbenOut : hCbenEn ? hCben : ~cbPrev;
  assign parW = !parOe_n ? parOut : hParEn ? hPar : ~parPrev;
  // control lines are pulled up
  assign frameW_n = !frameOe_n ? frameOut_n : hMstEn ? hFrame_n : 1'b1;
  assign irdyW_n = !irdyOe_n ? irdyOut_n : hMstEn ? hIrdy_n : 1'b1;
  assign trdyW_n = !trdyOe_n ? trdyOut_n : hTgtEn ? hTrdy_n : 1'b1;
  assign devselW_n = !devselOe_n ? devselOut_n : hTgtEn ? hDevsel_n : 1'b1;
  assign stopW_n = !stopOe_n ? stopOut_n : 1'b1;
  pbi_pci_core u_pbi_pci_core (.clk, .reset_n, .adIn(adW), .adOut, .adOe_n,
    .cbenIn(cbenW), .cbenOut, .cbenOe_n, .parIn(parW), .parOut, .parOe_n,
    .frameIn_n(frameW_n), .frameOut_n, .frameOe_n, .irdyIn_n(irdyW_n), .irdyOut_n,
    .irdyOe_n, .trdyIn_n(trdyW_n), .trdyOut_n, .trdyOe_n, .devselIn_n(devselW_n),
    .devselOut_n, .devselOe_n, .stopIn_n(stopW_n), .stopOut_n, .stopOe_n, .reqOut_n,
    .reqOe_n, .gntIn_n, .twValid, .twReady, .twData, .twBe, .parErr, .trAddr,
    .trData(rdPat), .mValid, .mAddr, .mData, .mBe, .mDone, .mAbort);
  pbi_host_model u_pbi_host_model (.clk, .adW, .cbenW, .frameW_n, .irdyW_n,
    .trdyW_n, .devselW_n, .stopW_n, .hAd, .hAdEn, .hCben, .hCbenEn, .hPar, .hParEn,
    .hFrame_n, .hIrdy_n, .hMstEn, .hTrdy_n, .hDevsel_n, .hTgtEn);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (errCount == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic waitM();
    for (int i = 0; i < 80 && mDone !== 1'b1 && mAbort !== 1'b1; i++) @(posedge clk);
  endtask
  // line history, grants, and a cut-off for a hung run
  always @(posedge clk) begin
    adPrev <= adW;
    cbPrev <= cbenW;
    parPrev <= parW;
    gntIn_n <= !(reqOe_n === 1'b0 && reqOut_n === 1'b0 && !hMstEn);
    cyc++;
    if (cyc == 5000) begin
      errCount++;
      print_verdict();
    end
  end
  // core parity one clock after it drove the lines
  always @(posedge clk) begin
    if (pChk) chk({parOe_n, parW}, {1'b0, pExp});
    pChk <= reset_n && !adOe_n && (!cbenOe_n || !trdyW_n);
    pExp <= ^{adW, cbenW};
  end
  // words leave the buffer in bus order with their lanes
  always @(posedge clk) begin
    if (reset_n && parErr !== 1'b0) chk(parErr, 1'b0);
    if (twValid === 1'b1 && twReady) begin
      if (expQ.size() == 0) chk(36'h0, 36'h1);
      else chk({twBe, twData}, expQ.pop_front());
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    chk({adOe_n, cbenOe_n, parOe_n, frameOe_n, irdyOe_n, trdyOe_n, devselOe_n,
      stopOe_n, reqOe_n}, 36'h1ff);
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({adOe_n, cbenOe_n, parOe_n, frameOe_n, irdyOe_n, trdyOe_n, devselOe_n,
      stopOe_n, reqOut_n}, 36'h1ff);
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      d0 = {r.addr[15:0], ~r.addr[15:0]};
      for (int k = 0; k < r.expN; k++) expQ.push_back({~r.be, d0 + k});
      repeat (2) @(posedge clk);
      u_pbi_host_model.xfer(r.addr, 4'h7, d0, r.be, r.n);
      chk(u_pbi_host_model.wordsDone, r.expN);
      chk(u_pbi_host_model.dselLat, r.expLat);
    end
    for (int k = 0; k < 2; k++) begin
      rdPat <= 32'h5a00_00c3 + k;
      repeat (2) @(posedge clk);
      u_pbi_host_model.xfer(32'h8004_0008, 4'h6, 32'h0, {4{k[0]}}, 1);
      chk(u_pbi_host_model.rdData, 32'h5a00_00c3 + k);
    end
    u_pbi_host_model.tgtOn <= 1'b1;
    mAddr <= 32'h1234_567b;
    mData <= 32'hfeed_0042;
    mBe <= 4'h9;
    mValid <= 1'b1;
    waitM();
    mValid <= 1'b0;
    chk({mDone, mAbort}, 36'h2);
    chk(u_pbi_host_model.capAddr, 32'h1234_5678);
    chk({u_pbi_host_model.capCben, u_pbi_host_model.capData}, 36'h6_feed_0042);
    repeat (3) @(posedge clk);
    u_pbi_host_model.tgtOn <= 1'b0;
    mValid <= 1'b1;
    waitM();
    mValid <= 1'b0;
    chk({mDone, mAbort}, 36'h1);
    // stall the user side so the buffer fills, then drain it
    for (int k = 0; k < 32; k++) expQ.push_back({4'hf, 32'h0bad_0000 + k});
    twReady <= 1'b0;
    fork
      u_pbi_host_model.xfer(32'h8000_0100, 4'h7, 32'h0bad_0000, 4'h0, 32);
      begin
        repeat (200) @(posedge clk);
        chk(u_pbi_host_model.wordsDone inside {[28:32]}, 1'b1);
        twReady <= 1'b1;
      end
    join
    repeat (60) @(posedge clk);
    chk(expQ.size(), 0);
    print_verdict();
  end
endmodule
`default_nettype wire
